// ---- design/tsa_sensor.sv ----
// Summary of operation
// - Select high: ignore link, release data line
// - Falling select starts frame; data line shared
// - Exactly 24 clocks or frame discarded
// - Write bits sampled on rising clock
// - Read bits updated on falling clock
// - Command and data sent MSB first
// - First eight clocks carry command byte
// - Sixteen data clocks, direction by command
// - Read drives from eighth fall until deselect
// - Continuous conversion, result twice per second
// - Bits 11/10 pick warning/critical polarity
// - Bit 9 picks latched warning mode
// - Bit 12: alarms need four faulty conversions
// - Bit 8 stops conversion and alarms
// - Shutdown keeps all registers and result
// - Reserved control bits ignored, reset zero
// - Latched warning on limit breach stays on
// - Temperature read clears latched warning
// - Re-asserts only past the deadband point
// - Comparator warning with deadband, reads ignored
// - Critical pin comparator with deadband only
// - Command: start bit, read bit, eleven codes
// - Any valid access restarts conversion
// - Result: 13-bit signed, three flag bits
// - Limits: nine signed bits, whole degrees
`timescale 1ns/1ps
`default_nettype none
module tsa_sensor
   import tsa_pkg::*;
#(
   parameter int unsigned CONV_CYCLES_P = CONV_CYCLES
) (
   input wire logic core_clk,           // Core clock, 100 MHz
   input wire logic reset_n,            // Async reset, active low
   input wire logic select_n,           // Frame select from master
   input wire logic serial_clock_in,    // Link clock from master
   input wire logic sio_i,              // Data line level
   output logic sio_o,                  // Data line drive value
   output logic sio_oe_n,               // Data line enable, low drives
   input wire logic [12:0] temp_code_in, // Converter result, 1/16 degree
   output logic warning_pin_o,          // Warning open-drain value
   output logic warning_pin_oe_n,       // Warning pull-down, low drives
   output logic critical_pin_o,         // Critical open-drain value
   output logic critical_pin_oe_n       // Critical pull-down, low drives
);

   function automatic logic cmd_ok(input logic [7:0] c);
      logic [2:0] idx;
      idx = c[3:1];
      cmd_ok = c[CMD_START_BIT] && c[5:4] == 2'h0 && c[0] && idx <= IDX_UPPER
         && (c[CMD_READ_BIT] || idx != IDX_TEMP);
   endfunction

   function automatic logic signed [13:0] lim14(input logic [8:0] l);
      lim14 = {l[8], l, 4'h0};
   endfunction

   function automatic logic signed [13:0] band14(input logic [8:0] l, input logic [8:0] h,
                                                  input logic up);
      logic [9:0] s;
      s = up ? {l[8], l} + {h[8], h} : {l[8], l} - {h[8], h};
      band14 = {s, 4'h0};
   endfunction

   function automatic logic qual(input logic [1:0] cnt, input logic cond, input logic fq);
      qual = cond && (!fq || cnt == QUEUE_FULL);
   endfunction

   // ---------------- Link side, clocked by the master ----------------
   typedef struct packed {
      logic [4:0] cnt;
      logic [15:0] sh;
      logic [7:0] cmd;
      logic tgl;
   } tsa_rise_t;

   typedef struct packed {
      logic oe_n;
      logic o;
      logic [15:0] sh;
   } tsa_fall_t;

   tsa_rise_t rise_reg, rise_next;
   tsa_fall_t fall_reg, fall_next;
   logic armed_reg;
   logic link_clr;
   logic [15:0] rd_word;

   // Select high also clears the frame state while the link clock is idle
   assign link_clr = select_n | ~reset_n;

   always_ff @(posedge serial_clock_in or posedge link_clr) begin
      if (link_clr) begin
         armed_reg <= 1'b1;
      end else begin
         armed_reg <= 1'b0;
      end
   end

   always_comb begin
      rise_next = rise_reg;
      rise_next.sh = {rise_reg.sh[14:0], sio_i};
      if (armed_reg) begin
         rise_next.cnt = 5'h01;
      end else if (rise_reg.cnt != CNT_SAT) begin
         rise_next.cnt = rise_reg.cnt + 5'h01;
      end
      if (!armed_reg && rise_reg.cnt == CMD_CLOCKS - 5'h01) begin
         rise_next.cmd = {rise_reg.sh[6:0], sio_i};
         rise_next.tgl = ~rise_reg.tgl;
      end
   end

   always_ff @(posedge serial_clock_in or negedge reset_n) begin
      if (!reset_n) begin
         rise_reg <= '0;
      end else begin
         rise_reg <= rise_next;
      end
   end

   always_comb begin
      fall_next = fall_reg;
      if (rise_reg.cnt == CMD_CLOCKS && cmd_ok(rise_reg.cmd)
          && rise_reg.cmd[CMD_READ_BIT] && fall_reg.oe_n) begin
         fall_next.oe_n = 1'b0;
         fall_next.o = rd_word[15];
         fall_next.sh = {rd_word[14:0], 1'b0};
      end else if (!fall_reg.oe_n) begin
         fall_next.o = fall_reg.sh[15];
         fall_next.sh = {fall_reg.sh[14:0], 1'b0};
      end
   end

   always_ff @(negedge serial_clock_in or posedge link_clr) begin
      if (link_clr) begin
         fall_reg <= '{oe_n: 1'b1, o: 1'b0, sh: 16'h0000};
      end else begin
         fall_reg <= fall_next;
      end
   end

   assign sio_o = fall_reg.o;
   assign sio_oe_n = fall_reg.oe_n;

   // ---------------- Core side ----------------
   typedef struct packed {
      logic sel_s1;
      logic sel_s2;
      logic sel_s3;
      logic tg_s1;
      logic tg_s2;
      logic tg_s3;
      logic [15:0] ctrl;
      logic [8:0] deadband;
      logic [8:0] crit;
      logic [8:0] lower;
      logic [8:0] upper;
      logic [15:0] temp;
      logic [15:0] rd_word;
      logic [31:0] conv_cnt;
      logic [5:0][1:0] qc;
      tsa_warn_t warn_st;
      tsa_src_t warn_src;
      logic crit_act;
      logic warn_oe_n;
      logic crit_oe_n;
   } tsa_core_t;

   tsa_core_t st_reg, st_next;
   logic conv_done, commit, commit_ok, temp_read;
   logic signed [13:0] ts;
   logic [5:0] cond, q;

   assign ts = {temp_code_in[12], temp_code_in};
   // Link words are quiet here: sclk is idle while select is high
   assign commit = st_reg.sel_s2 && !st_reg.sel_s3;
   assign commit_ok = commit && rise_reg.cnt == FRAME_CLOCKS && cmd_ok(rise_reg.cmd);
   assign temp_read = commit_ok && rise_reg.cmd[3:1] == IDX_TEMP;
   assign conv_done = !st_reg.ctrl[CTRL_SHUTDOWN]
      && st_reg.conv_cnt == 32'(CONV_CYCLES_P - 1);
   assign rd_word = st_reg.rd_word;

   always_comb begin
      cond[Q_HI] = ts > lim14(st_reg.upper);
      cond[Q_LO] = ts < lim14(st_reg.lower);
      cond[Q_CR] = ts > lim14(st_reg.crit);
      cond[Q_HI_CLR] = ts < band14(st_reg.upper, st_reg.deadband, 1'b0);
      cond[Q_LO_CLR] = ts > band14(st_reg.lower, st_reg.deadband, 1'b1);
      cond[Q_CR_CLR] = ts < band14(st_reg.crit, st_reg.deadband, 1'b0);
      for (int i = 0; i < 6; i++) begin
         q[i] = qual(st_reg.qc[i], cond[i], st_reg.ctrl[CTRL_QUEUE]);
      end
   end

   always_comb begin
      st_next = st_reg;
      st_next.sel_s1 = select_n;
      st_next.sel_s2 = st_reg.sel_s1;
      st_next.sel_s3 = st_reg.sel_s2;
      st_next.tg_s1 = rise_reg.tgl;
      st_next.tg_s2 = st_reg.tg_s1;
      st_next.tg_s3 = st_reg.tg_s2;

      // Command byte landed: stage the read word well before the eighth fall
      if (st_reg.tg_s2 != st_reg.tg_s3) begin
         case (rise_reg.cmd[3:1])
            IDX_TEMP: st_next.rd_word = st_reg.temp;
            IDX_CTRL: st_next.rd_word = st_reg.ctrl;
            IDX_DEADBAND: st_next.rd_word = {st_reg.deadband, 7'h00};
            IDX_CRIT: st_next.rd_word = {st_reg.crit, 7'h00};
            IDX_LOWER: st_next.rd_word = {st_reg.lower, 7'h00};
            IDX_UPPER: st_next.rd_word = {st_reg.upper, 7'h00};
            default: st_next.rd_word = 16'h0000;
         endcase
      end

      if (commit_ok) begin
         st_next.conv_cnt = 32'h0;
         if (!rise_reg.cmd[CMD_READ_BIT]) begin
            case (rise_reg.cmd[3:1])
               IDX_CTRL: st_next.ctrl = rise_reg.sh & CTRL_WMASK;
               IDX_DEADBAND: st_next.deadband = rise_reg.sh[15:LIMIT_LSB];
               IDX_CRIT: st_next.crit = rise_reg.sh[15:LIMIT_LSB];
               IDX_LOWER: st_next.lower = rise_reg.sh[15:LIMIT_LSB];
               IDX_UPPER: st_next.upper = rise_reg.sh[15:LIMIT_LSB];
               default: st_next.ctrl = st_reg.ctrl;
            endcase
         end
      end else if (!st_reg.ctrl[CTRL_SHUTDOWN]) begin
         st_next.conv_cnt = conv_done ? 32'h0 : st_reg.conv_cnt + 32'h1;
      end

      // Read clears a latched warning; a conversion in the same cycle may set it again
      if (temp_read && st_reg.ctrl[CTRL_INTR_MODE] && st_reg.warn_st == TSA_W_ACT) begin
         st_next.warn_st = (st_reg.warn_src == TSA_SRC_RET) ? TSA_W_IDLE : TSA_W_WAIT;
      end

      if (conv_done) begin
         st_next.temp = {temp_code_in, cond[Q_CR], cond[Q_HI], cond[Q_LO]};
         for (int i = 0; i < 6; i++) begin
            st_next.qc[i] = !cond[i] ? 2'h0 :
               (st_reg.qc[i] == QUEUE_FULL ? QUEUE_FULL : st_reg.qc[i] + 2'h1);
         end
         case (st_next.warn_st)
            TSA_W_IDLE: begin
               if (q[Q_HI]) begin
                  st_next.warn_st = TSA_W_ACT;
                  st_next.warn_src = TSA_SRC_HI;
               end else if (q[Q_LO]) begin
                  st_next.warn_st = TSA_W_ACT;
                  st_next.warn_src = TSA_SRC_LO;
               end
            end
            TSA_W_ACT: begin
               if (!st_reg.ctrl[CTRL_INTR_MODE] && st_reg.warn_src != TSA_SRC_RET
                   && (st_reg.warn_src == TSA_SRC_HI ? q[Q_HI_CLR] : q[Q_LO_CLR])) begin
                  st_next.warn_st = TSA_W_IDLE;
               end
            end
            TSA_W_WAIT: begin
               if (st_reg.warn_src == TSA_SRC_HI ? q[Q_HI_CLR] : q[Q_LO_CLR]) begin
                  st_next.warn_st = TSA_W_ACT;
                  st_next.warn_src = TSA_SRC_RET;
               end
            end
            default: st_next.warn_st = TSA_W_IDLE;
         endcase
         // A stale latched state left after a switch to comparator mode
         if (!st_reg.ctrl[CTRL_INTR_MODE] && st_next.warn_st == TSA_W_WAIT) begin
            st_next.warn_st = TSA_W_IDLE;
         end
         if (q[Q_CR]) begin
            st_next.crit_act = 1'b1;
         end else if (q[Q_CR_CLR]) begin
            st_next.crit_act = 1'b0;
         end
      end

      // Open drain: pull low whenever the wanted level is low
      st_next.warn_oe_n = ~((st_next.warn_st == TSA_W_ACT) ^ st_next.ctrl[CTRL_WARN_POL]);
      st_next.crit_oe_n = ~(st_next.crit_act ^ st_next.ctrl[CTRL_CRIT_POL]);
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         st_reg <= '{sel_s1: 1'b1, sel_s2: 1'b1, sel_s3: 1'b1,
                     tg_s1: 1'b0, tg_s2: 1'b0, tg_s3: 1'b0,
                     ctrl: CTRL_RESET,
                     deadband: DEADBAND_RESET[15:LIMIT_LSB],
                     crit: CRIT_RESET[15:LIMIT_LSB],
                     lower: LOWER_RESET[15:LIMIT_LSB],
                     upper: UPPER_RESET[15:LIMIT_LSB],
                     temp: TEMP_RESET, rd_word: 16'h0000, conv_cnt: 32'h0,
                     qc: '0, warn_st: TSA_W_IDLE, warn_src: TSA_SRC_HI,
                     crit_act: 1'b0, warn_oe_n: 1'b1, crit_oe_n: 1'b1};
      end else begin
         st_reg <= st_next;
      end
   end

   assign warning_pin_o = 1'b0 & st_reg.warn_oe_n;
   assign warning_pin_oe_n = st_reg.warn_oe_n;
   assign critical_pin_o = 1'b0 & st_reg.crit_oe_n;
   assign critical_pin_oe_n = st_reg.crit_oe_n;

   // ---------------- Checks ----------------
   sequence s_read_cmd_in;
      rise_reg.cnt == CMD_CLOCKS && cmd_ok(rise_reg.cmd) && rise_reg.cmd[CMD_READ_BIT];
   endsequence

   sequence s_latched_read;
      temp_read && st_reg.ctrl[CTRL_INTR_MODE] && st_reg.warn_st == TSA_W_ACT && !conv_done;
   endsequence

   property p_idle_release;
      @(posedge core_clk) disable iff (!reset_n) st_reg.sel_s2 |-> sio_oe_n;
   endproperty
   a_idle_release: assert property (p_idle_release) else $error("data line driven while idle");

   property p_drive_at_eighth;
      @(negedge serial_clock_in) disable iff (select_n || !reset_n)
         s_read_cmd_in |=> !sio_oe_n && sio_o == $past(rd_word[15]) ##1 !sio_oe_n;
   endproperty
   a_drive_at_eighth: assert property (p_drive_at_eighth) else $error("read not driven");

   property p_write_needs_frame;
      @(posedge core_clk) disable iff (!reset_n)
         $changed(st_reg.ctrl) || $changed(st_reg.upper) |-> $past(commit_ok);
   endproperty
   a_write_needs_frame: assert property (p_write_needs_frame) else $error("bad frame wrote");

   property p_ctrl_reserved;
      @(posedge core_clk) disable iff (!reset_n) (st_reg.ctrl & ~CTRL_WMASK) == 16'h0000;
   endproperty
   a_ctrl_reserved: assert property (p_ctrl_reserved) else $error("reserved bit set");

   property p_result_capture;
      @(posedge core_clk) disable iff (!reset_n)
         conv_done |=> st_reg.temp[15:TEMP_LSB] == $past(temp_code_in) && st_reg.conv_cnt == 32'h0;
   endproperty
   a_result_capture: assert property (p_result_capture) else $error("result not stored");

   property p_shutdown_hold;
      @(posedge core_clk) disable iff (!reset_n)
         st_reg.ctrl[CTRL_SHUTDOWN] && !commit_ok |=> $stable(st_reg.temp)
            && $stable(st_reg.crit_act) && $stable(st_reg.conv_cnt);
   endproperty
   a_shutdown_hold: assert property (p_shutdown_hold) else $error("shutdown not frozen");

   property p_read_clears;
      @(posedge core_clk) disable iff (!reset_n)
         s_latched_read |=> st_reg.warn_st != TSA_W_ACT ##1 warning_pin_oe_n == !st_reg.ctrl[CTRL_WARN_POL];
   endproperty
   a_read_clears: assert property (p_read_clears) else $error("read did not clear");

   property p_queue_holds;
      @(posedge core_clk) disable iff (!reset_n)
         st_reg.ctrl[CTRL_QUEUE] && conv_done && st_reg.warn_st == TSA_W_IDLE
            && st_reg.qc[Q_HI] != QUEUE_FULL && st_reg.qc[Q_LO] != QUEUE_FULL
            |=> st_reg.warn_st == TSA_W_IDLE;
   endproperty
   a_queue_holds: assert property (p_queue_holds) else $error("queue bypassed");

   property p_crit_follow;
      @(posedge core_clk) disable iff (!reset_n)
         conv_done && q[Q_CR] |=> st_reg.crit_act ##1 critical_pin_oe_n == st_reg.ctrl[CTRL_CRIT_POL];
   endproperty
   a_crit_follow: assert property (p_crit_follow) else $error("critical not raised");

   property p_comparator_no_clear;
      @(posedge core_clk) disable iff (!reset_n)
         temp_read && !st_reg.ctrl[CTRL_INTR_MODE] && st_reg.warn_st == TSA_W_ACT && !conv_done
            |=> st_reg.warn_st == TSA_W_ACT;
   endproperty
   a_comparator_no_clear: assert property (p_comparator_no_clear) else $error("read cleared");

endmodule
`default_nettype wire

// ---- design/tsa_pkg.sv ----
package tsa_pkg;
   // Core clock and conversion pacing
   localparam int CLK_HZ = 100_000_000;
   localparam int CONV_PERIOD_MS = 500;
   localparam int CONV_CYCLES = CLK_HZ / 1000 * CONV_PERIOD_MS;

   // Serial frame shape
   localparam logic [4:0] FRAME_CLOCKS = 5'h18;
   localparam logic [4:0] CMD_CLOCKS = 5'h08;
   localparam logic [4:0] CNT_SAT = 5'h1f;

   // Command byte fields
   localparam int CMD_START_BIT = 7;
   localparam int CMD_READ_BIT = 6;
   localparam logic [2:0] IDX_TEMP = 3'h0;
   localparam logic [2:0] IDX_CTRL = 3'h1;
   localparam logic [2:0] IDX_DEADBAND = 3'h2;
   localparam logic [2:0] IDX_CRIT = 3'h3;
   localparam logic [2:0] IDX_LOWER = 3'h4;
   localparam logic [2:0] IDX_UPPER = 3'h5;

   // Control register fields
   localparam int CTRL_SHUTDOWN = 8;
   localparam int CTRL_INTR_MODE = 9;
   localparam int CTRL_CRIT_POL = 10;
   localparam int CTRL_WARN_POL = 11;
   localparam int CTRL_QUEUE = 12;
   localparam logic [15:0] CTRL_WMASK = 16'h1f00;
   localparam logic [15:0] CTRL_RESET = 16'h0000;

   // Limit registers keep the upper nine bits only
   localparam int LIMIT_LSB = 7;
   localparam int TEMP_LSB = 3;
   localparam logic [15:0] LOWER_RESET = 16'h0500;
   localparam logic [15:0] UPPER_RESET = 16'h2000;
   localparam logic [15:0] DEADBAND_RESET = 16'h0100;
   localparam logic [15:0] CRIT_RESET = 16'h4b00;
   localparam logic [15:0] TEMP_RESET = 16'h0000;

   // Fault streak counters, one per comparison
   localparam int Q_HI = 0;
   localparam int Q_LO = 1;
   localparam int Q_CR = 2;
   localparam int Q_HI_CLR = 3;
   localparam int Q_LO_CLR = 4;
   localparam int Q_CR_CLR = 5;
   localparam logic [1:0] QUEUE_FULL = 2'h3;

   typedef enum logic [1:0] {
      TSA_W_IDLE = 2'b00,
      TSA_W_ACT = 2'b01,
      TSA_W_WAIT = 2'b11
   } tsa_warn_t;

   typedef enum logic [1:0] {
      TSA_SRC_HI = 2'b00,
      TSA_SRC_LO = 2'b01,
      TSA_SRC_RET = 2'b11
   } tsa_src_t;
endpackage

// ---- verification/tsa_master_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module tsa_master_model (
   output var logic select_n,        // Frame select, idle high
   output var logic serial_clock_in, // Link clock, still outside frames
   output var logic m_val,           // Master drive value or float pattern
   input wire logic sio_lvl,         // Resolved data line
   input wire logic sio_oe_n         // Device drive enable
);
   initial begin
      select_n = 1'b1;
      serial_clock_in = 1'b0;
      m_val = 1'b0;
   end

   // 200 ns halves: the read word must be staged before fall 8
   task automatic xfer(input logic [7:0] cmd, input int nclk, input logic [15:0] wd,
         output logic [15:0] rd, output logic [23:0] oe);
      logic [23:0] sh;
      logic drv;
      sh = {cmd, wd};
      rd = 16'h0000;
      oe = 24'h000000;
      drv = 1'b1;
      select_n = 1'b0;
      m_val = sh[23];
      #150;
      for (int k = 1; k <= nclk; k++) begin
         serial_clock_in = 1'b1;
         rd = {rd[14:0], sio_lvl};
         oe[k-1] = ~sio_oe_n;
         #5;
         if (k == 8 && cmd[7:6] == 2'b11) begin
            drv = 1'b0;
         end
         if (!drv) begin
            m_val = ~m_val;
         end
         #195;
         serial_clock_in = 1'b0;
         #5;
         if (drv && k < 24) begin
            m_val = sh[23-k];
         end else begin
            m_val = ~m_val;
         end
         #195;
      end
      select_n = 1'b1;
      m_val = ~m_val;
      #250;
   endtask
endmodule
`default_nettype wire

// ---- verification/temp_sensor_serial_alarm_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module temp_sensor_serial_alarm_tb_top;
   import tsa_pkg::*;
   localparam int CONV_P = 50;
   logic core_clk, reset_n, select_n, serial_clock_in, sio_o, sio_oe_n, m_val, sio_lvl;
   logic warning_pin_o, warning_pin_oe_n, critical_pin_o, critical_pin_oe_n;
   logic [12:0] temp_code_in;
   logic [15:0] ctrl, crit_l, upper_l, lower_l, rdv;
   logic [23:0] oev;
   logic [31:0] lfsr;
   logic [15:0] defs [4] = '{DEADBAND_RESET, CRIT_RESET, LOWER_RESET, UPPER_RESET};
   logic [7:0] bad_cmd [5] = '{8'h83, 8'h83, 8'h81, 8'h03, 8'hc2};
   int bad_n [5] = '{23, 25, 24, 24, 24};
   int corner [4] = '{1024, 1025, 160, 159};
   int error_cnt, checks_done, c;
   // Released line shows a changing pattern, not the last bit
   assign sio_lvl = !sio_oe_n ? sio_o : m_val;

   tsa_sensor #(.CONV_CYCLES_P(CONV_P)) tsa_sensor_i (
      .core_clk(core_clk), .reset_n(reset_n), .select_n(select_n),
      .serial_clock_in(serial_clock_in), .sio_i(sio_lvl), .sio_o(sio_o),
      .sio_oe_n(sio_oe_n), .temp_code_in(temp_code_in), .warning_pin_o(warning_pin_o),
      .warning_pin_oe_n(warning_pin_oe_n), .critical_pin_o(critical_pin_o),
      .critical_pin_oe_n(critical_pin_oe_n));

   tsa_master_model tsa_master_model_i (
      .select_n(select_n), .serial_clock_in(serial_clock_in), .m_val(m_val),
      .sio_lvl(sio_lvl), .sio_oe_n(sio_oe_n));

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   function automatic logic [31:0] lfsr_next(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   function automatic logic [15:0] tword(input int v);
      int cr, hi, lo;
      cr = $signed(crit_l[15:7]) * 16;
      hi = $signed(upper_l[15:7]) * 16;
      lo = $signed(lower_l[15:7]) * 16;
      return {13'(v), v > cr, v > hi, v < lo};
   endfunction

   task automatic results;
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic wr(input logic [7:0] cmd, input logic [15:0] d);
      tsa_master_model_i.xfer(cmd, 24, d, rdv, oev);
      `CHK(oev, 24'h000000)
      `CHK(sio_oe_n, 1'b1)
      case (cmd)
         8'h83: ctrl = d & CTRL_WMASK;
         8'h87: crit_l = d & 16'hff80;
         8'h89: lower_l = d & 16'hff80;
         8'h8b: upper_l = d & 16'hff80;
         default: ;
      endcase
   endtask

   task automatic rd_chk(input logic [7:0] cmd, input logic [15:0] e);
      tsa_master_model_i.xfer(cmd, 24, 16'h0000, rdv, oev);
      `CHK(oev, 24'hffff00)
      `CHK(rdv, e)
      `CHK(sio_oe_n, 1'b1)
   endtask

   // Pin level equals its enable, since the line is pulled up
   task automatic pins(input logic wa, input logic ca);
      `CHK(warning_pin_oe_n, wa ? ctrl[11] : !ctrl[11])
      `CHK(critical_pin_oe_n, ca ? ctrl[10] : !ctrl[10])
   endtask

   task automatic settle(input int v, input int n);
      @(posedge core_clk);
      #1;
      temp_code_in = 13'(v);
      repeat (n) @(posedge core_clk);
      #1;
   endtask

   initial begin
      #900_000;
      error_cnt++;
      results;
   end

   initial begin
      temp_code_in = 13'(400);
      reset_n = 1'b0;
      lfsr = 32'hafc2c793;
      ctrl = CTRL_RESET;
      crit_l = CRIT_RESET;
      upper_l = UPPER_RESET;
      lower_l = LOWER_RESET;
      error_cnt = 0;
      checks_done = 0;
      repeat (6) @(posedge core_clk);
      #1;
      reset_n = 1'b1;
      repeat (3) @(posedge core_clk);
      `CHK(warning_pin_o, 1'b0)
      pins(1'b0, 1'b0);
      rd_chk(8'hc3, CTRL_RESET);
      for (int i = 0; i < 4; i++) begin
         rd_chk(8'hc5 + 8'(2 * i), defs[i]);
      end
      wr(8'h83, 16'hffff);
      rd_chk(8'hc3, 16'h1f00);
      wr(8'h83, 16'h0000);
      for (int i = 0; i < 4; i++) begin
         lfsr = lfsr_next(lfsr);
         wr(8'h85 + 8'(2 * i), lfsr[15:0]);
         rd_chk(8'hc5 + 8'(2 * i), lfsr[15:0] & 16'hff80);
         wr(8'h85 + 8'(2 * i), defs[i]);
      end
      for (int i = 0; i < 5; i++) begin
         tsa_master_model_i.xfer(bad_cmd[i], bad_n[i], 16'h1f00, rdv, oev);
         `CHK(oev, 24'h000000)
      end
      rd_chk(8'hc3, 16'h0000);
      for (int i = 0; i < 8; i++) begin
         lfsr = lfsr_next(lfsr);
         c = (i < 4) ? corner[i] : int'(lfsr % 32'd3281) - 880;
         settle(c, 110);
         rd_chk(8'hc1, tword(c));
      end
      wr(8'h87, 16'h2800);
      settle(400, 110);
      pins(1'b0, 1'b0);
      // Latched warning
      wr(8'h83, 16'h0200);
      settle(1120, 110);
      pins(1'b1, 1'b0);
      rd_chk(8'hc1, tword(1120));
      pins(1'b0, 1'b0);
      settle(1120, 110);
      pins(1'b0, 1'b0);
      settle(480, 110);
      pins(1'b1, 1'b0);
      rd_chk(8'hc1, tword(480));
      settle(480, 110);
      pins(1'b0, 1'b0);
      // Polarity and comparator deadband
      wr(8'h83, 16'h0e00);
      pins(1'b0, 1'b0);
      settle(1360, 110);
      pins(1'b1, 1'b1);
      wr(8'h83, 16'h0000);
      settle(1264, 110);
      pins(1'b1, 1'b1);
      rd_chk(8'hc1, tword(1264));
      pins(1'b1, 1'b1);
      settle(1232, 110);
      pins(1'b1, 1'b0);
      settle(1008, 110);
      pins(1'b1, 1'b0);
      settle(976, 110);
      pins(1'b0, 1'b0);
      // Fault queue, counted from the restart at commit
      wr(8'h83, 16'h1000);
      settle(1120, 150);
      pins(1'b0, 1'b0);
      repeat (50) @(posedge core_clk);
      pins(1'b1, 1'b0);
      settle(400, 260);
      pins(1'b0, 1'b0);
      // Shutdown freezes result and alarms
      wr(8'h83, 16'h0100);
      settle(1600, 110);
      rd_chk(8'hc1, tword(400));
      pins(1'b0, 1'b0);
      wr(8'h83, 16'h0000);
      settle(1600, 110);
      rd_chk(8'hc1, tword(1600));
      pins(1'b1, 1'b1);
      results;
   end
endmodule
`default_nettype wire
